// >>> verilog/ueba_top.sv
// endpoint buffer access logic with its write fifo
`default_nettype none
`include "ueba_params.svh"

module ueba_fifo #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 4
) (
   input wire logic i_clk,
   input wire logic i_arst_n,
   input wire logic i_in_valid,
   output var logic o_in_ready,
   input wire logic [WIDTH-1:0] i_in_data,
   output var logic o_out_valid,
   input wire logic i_out_ready,
   output var logic [WIDTH-1:0] o_out_data
);
   localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
   logic [WIDTH-1:0] buf_ff [DEPTH];
   logic [AW-1:0] wp_ff, rp_ff;
   logic [AW:0] cnt_ff, nxt_cnt;
   logic push, pop;

   assign push = i_in_valid && o_in_ready;
   assign pop = o_out_valid && i_out_ready;
   assign nxt_cnt = cnt_ff + (AW+1)'(push) - (AW+1)'(pop);
   assign o_out_data = buf_ff[rp_ff];
   always_ff @(posedge i_clk) begin
      if (push) begin
         buf_ff[wp_ff] <= i_in_data;
      end
   end
   always_ff @(posedge i_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         wp_ff <= '0;
         rp_ff <= '0;
         cnt_ff <= '0;
         o_in_ready <= 1'b1;
         o_out_valid <= 1'b0;
      end else begin
         if (push) begin
            wp_ff <= (wp_ff == AW'(DEPTH-1)) ? '0 : wp_ff + 1'b1;
         end
         if (pop) begin
            rp_ff <= (rp_ff == AW'(DEPTH-1)) ? '0 : rp_ff + 1'b1;
         end
         cnt_ff <= nxt_cnt;
         o_in_ready <= (nxt_cnt < (AW+1)'(DEPTH));
         o_out_valid <= (nxt_cnt != '0);
      end
   end
endmodule : ueba_fifo
////////////////////////////////////////////////////////////////////////////
// What this block does
// - clear command zeroes the offset and both buffer full flags
// - clear command self-clears, reads zero, keeps the direction
// - endpoint zero: clear with status enable keeps it, alone clears it
// - clear with a direction prediction ignores the prediction
// - done marks cpu buffer full or empty by direction, reads zero
// - done in usb-read direction with auto-increment copies offset
// - page select picks page in single mode, ignored in dual mode
// - setup bytes always land at page zero, addresses 00 to 07
// - base bits 6..2 give start address bits 7..3, low bits zero
// - length is seven bits, bit 7 zero, cpu writes locked while init lock set; the copy on done still loads it
// - offset is six bits, upper two bits read zero
// - data port writes and reads the byte at base plus offset
// - data port moves data only under the same legal condition
// - illegal data port access sets the no-data flag
// - every endpoint has its own base, length, offset and data
// - auto-increment advances the offset after each accepted data access
// - direction reads zero for host to cpu, one for cpu to host
module ueba_top import ueba_pkg::*; #(
   parameter int NUM_EP = 16,
   parameter int FIFO_DEPTH = 4
) (
   input wire logic I_CLK,
   input wire logic I_ARST_N,
   input wire logic [3:0] I_EP_SEL,
   input wire logic [2:0] I_REG_SEL,
   input wire logic I_WR,
   input wire logic I_RD,
   input wire logic [7:0] I_WDATA,
   output var logic [7:0] O_RDATA,
   output var logic O_RD_VALID,
   output var logic O_WR_READY,
   input wire logic I_INIT_LOCK,
   input wire logic [NUM_EP-1:0] I_AUTO_INC,
   input wire logic [NUM_EP-1:0] I_DUAL_BUF,
   input wire logic [3:0] I_USB_EP,
   input wire logic I_USB_WE,
   input wire logic I_USB_RE,
   input wire logic [8:0] I_USB_ADDR,
   input wire logic [7:0] I_USB_WDATA,
   input wire logic I_USB_DONE,
   input wire logic I_USB_UBF_SET,
   input wire logic I_USB_UBF_CLR,
   input wire logic I_USB_DIR_SET,
   input wire logic I_USB_DIR,
   input wire logic I_USB_SETUP_WE,
   input wire logic [2:0] I_USB_SETUP_IDX,
   input wire logic I_STATUS_DONE,
   input wire logic [NUM_EP-1:0] I_NO_DATA_CLR,
   output var logic [7:0] O_USB_RDATA,
   output var logic [NUM_EP-1:0] O_NO_DATA,
   output var logic O_STATUS_PHASE_EN
);
   logic [7:0] mem [`UEBA_MEM_WORDS];
   logic [7:0] base_ff [NUM_EP];
   logic [6:0] len_ff [NUM_EP];
   logic [5:0] off_ff [NUM_EP];
   logic [NUM_EP-1:0] cbf_ff;
   logic [NUM_EP-1:0] ubf_ff;
   logic [NUM_EP-1:0] dir_ff;
   logic [NUM_EP-1:0] cpu_page_ff;
   ueba_reg_t sel;
   logic ep_dir, ep_cbf, ep_inc, legal, page;
   logic [7:0] low_addr;
   logic [8:0] cpu_addr;
   logic st_wr, clr, done, predict, data_wr_go, data_rd_go, data_bad;
   logic off_wr, len_wr, base_wr, drain_ok;
   logic fifo_ready, fifo_valid;
   logic [16:0] fifo_data;
   logic [8:0] setup_addr;
   ////////////////////////////////////////////////////////////////////////
   assign sel = ueba_reg_t'(I_REG_SEL);
   assign ep_dir = dir_ff[I_EP_SEL];
   assign ep_cbf = cbf_ff[I_EP_SEL];
   assign ep_inc = I_AUTO_INC[I_EP_SEL];
   assign legal = (!ep_dir && ep_cbf) || (ep_dir && !ep_cbf);
   assign page = I_DUAL_BUF[I_EP_SEL] ? cpu_page_ff[I_EP_SEL]
               : base_ff[I_EP_SEL][`UEBA_B_PAGE];
   assign low_addr = {base_ff[I_EP_SEL][`UEBA_B_ADR_HI:`UEBA_B_ADR_LO],
                      3'h0} + {2'h0, off_ff[I_EP_SEL]};
   assign cpu_addr = {page, low_addr};
   assign st_wr = I_WR && sel == UEBA_R_STAT;
   assign clr = st_wr && I_WDATA[`UEBA_B_CLR];
   assign done = st_wr && I_WDATA[`UEBA_B_DONE];
   assign predict = st_wr && !clr
                 && (I_WDATA[`UEBA_B_SETRD] ^ I_WDATA[`UEBA_B_SETWR]);
   assign off_wr = I_WR && sel == UEBA_R_OFF && legal;
   assign len_wr = I_WR && sel == UEBA_R_LEN && !I_INIT_LOCK;
   assign base_wr = I_WR && sel == UEBA_R_BASE;
   assign data_wr_go = I_WR && sel == UEBA_R_DATA && legal
                    && fifo_ready;
   assign data_rd_go = I_RD && sel == UEBA_R_DATA && legal
                    && !fifo_valid;
   assign data_bad = (I_WR || I_RD) && sel == UEBA_R_DATA && !legal;
   assign drain_ok = !I_USB_WE && !I_USB_SETUP_WE;
   assign setup_addr = {`UEBA_SETUP_PAGE, `UEBA_SETUP_BASE,
                        I_USB_SETUP_IDX};
   assign O_WR_READY = fifo_ready;
   ////////////////////////////////////////////////////////////////////////
   // cpu writes queue here; usb side writes stall the drain
   ueba_fifo #(.WIDTH(17), .DEPTH(FIFO_DEPTH)) u_wr_fifo (
      .i_clk(I_CLK),
      .i_arst_n(I_ARST_N),
      .i_in_valid(data_wr_go),
      .o_in_ready(fifo_ready),
      .i_in_data({cpu_addr, I_WDATA}),
      .o_out_valid(fifo_valid),
      .i_out_ready(drain_ok),
      .o_out_data(fifo_data)
   );
   always_ff @(posedge I_CLK) begin
      if (I_USB_SETUP_WE) begin
         mem[setup_addr] <= I_USB_WDATA;
      end else if (I_USB_WE) begin
         mem[I_USB_ADDR] <= I_USB_WDATA;
      end else if (fifo_valid) begin
         mem[fifo_data[16:8]] <= fifo_data[7:0];
      end
   end
   ////////////////////////////////////////////////////////////////////////
   // per-endpoint registers
   always_ff @(posedge I_CLK or negedge I_ARST_N) begin
      if (!I_ARST_N) begin
         for (int e = 0; e < NUM_EP; e++) begin
            base_ff[e] <= `UEBA_BASE_RST;
            len_ff[e] <= `UEBA_LEN_RST;
            off_ff[e] <= `UEBA_OFF_RST;
         end
      end else begin
         for (int e = 0; e < NUM_EP; e++) begin
            if (I_EP_SEL == 4'(e)) begin
               if (base_wr) begin
                  base_ff[e] <= {I_WDATA[7:2], 2'h0};
               end
               if (done && dir_ff[e] && I_AUTO_INC[e]) begin
                  len_ff[e] <= {1'h0, off_ff[e]};
               end else if (len_wr) begin
                  len_ff[e] <= I_WDATA[6:0];
               end
               if (clr) begin
                  off_ff[e] <= 6'h00;
               end else if (off_wr) begin
                  off_ff[e] <= I_WDATA[5:0];
               end else if ((data_wr_go || data_rd_go) && ep_inc) begin
                  off_ff[e] <= off_ff[e] + 6'h01;
               end
            end
         end
      end
   end
   // buffer flags; usb events come last so they beat a cpu command in the same cycle
   always_ff @(posedge I_CLK or negedge I_ARST_N) begin
      if (!I_ARST_N) begin
         cbf_ff <= '0;
         ubf_ff <= '0;
         dir_ff <= {NUM_EP{`UEBA_DIR_RST}};
         cpu_page_ff <= '0;
      end else begin
         for (int e = 0; e < NUM_EP; e++) begin
            if (I_EP_SEL == 4'(e)) begin
               if (clr) begin
                  cbf_ff[e] <= 1'b0;
                  ubf_ff[e] <= 1'b0;
               end else if (done) begin
                  cbf_ff[e] <= dir_ff[e];
                  cpu_page_ff[e] <= !cpu_page_ff[e];
               end
               if (predict && !cbf_ff[e] && !ubf_ff[e]) begin
                  dir_ff[e] <= I_WDATA[`UEBA_B_SETRD];
               end
            end
            if (I_USB_EP == 4'(e)) begin
               if (I_USB_DONE) begin
                  cbf_ff[e] <= !dir_ff[e];
               end
               if (I_USB_UBF_SET) begin
                  ubf_ff[e] <= 1'b1;
               end else if (I_USB_UBF_CLR) begin
                  ubf_ff[e] <= 1'b0;
               end
               if (I_USB_DIR_SET) begin
                  dir_ff[e] <= I_USB_DIR;
               end
            end
         end
      end
   end
   always_ff @(posedge I_CLK or negedge I_ARST_N) begin
      if (!I_ARST_N) begin
         O_STATUS_PHASE_EN <= 1'b0;
      end else if (st_wr && I_EP_SEL == 4'h0 && I_WDATA[`UEBA_B_ESP]) begin
         O_STATUS_PHASE_EN <= 1'b1;
      end else if (clr && I_EP_SEL == 4'h0) begin
         O_STATUS_PHASE_EN <= 1'b0;
      end else if (I_USB_SETUP_WE || I_STATUS_DONE) begin
         O_STATUS_PHASE_EN <= 1'b0;
      end
   end
   always_ff @(posedge I_CLK or negedge I_ARST_N) begin
      if (!I_ARST_N) begin
         O_NO_DATA <= '0;
      end else begin
         for (int e = 0; e < NUM_EP; e++) begin
            if (data_bad && I_EP_SEL == 4'(e)) begin
               O_NO_DATA[e] <= 1'b1;
            end else if (I_NO_DATA_CLR[e]) begin
               O_NO_DATA[e] <= 1'b0;
            end
         end
      end
   end
   ////////////////////////////////////////////////////////////////////////
   // read paths; command bits always read zero
   always_ff @(posedge I_CLK or negedge I_ARST_N) begin
      if (!I_ARST_N) begin
         O_RDATA <= `UEBA_DATA_RST;
         O_RD_VALID <= 1'b0;
      end else begin
         O_RD_VALID <= I_RD && (sel != UEBA_R_DATA || data_rd_go);
         if (I_RD) begin
            case (sel)
               UEBA_R_STAT: O_RDATA <= {ubf_ff[I_EP_SEL], ep_cbf,
                                        ep_dir, 5'h00};
               UEBA_R_BASE: O_RDATA <= base_ff[I_EP_SEL];
               UEBA_R_LEN: O_RDATA <= {1'h0, len_ff[I_EP_SEL]};
               UEBA_R_OFF: O_RDATA <= {2'h0, off_ff[I_EP_SEL]};
               UEBA_R_DATA: begin
                  if (data_rd_go) begin
                     O_RDATA <= mem[cpu_addr];
                  end
               end
               default: O_RDATA <= 8'h00;
            endcase
         end
      end
   end
   always_ff @(posedge I_CLK or negedge I_ARST_N) begin
      if (!I_ARST_N) begin
         O_USB_RDATA <= 8'h00;
      end else if (I_USB_RE) begin
         O_USB_RDATA <= mem[I_USB_ADDR];
      end
   end
   ////////////////////////////////////////////////////////////////////////
   default clocking cb @(posedge I_CLK); endclocking
   default disable iff (!I_ARST_N);
   logic usb_quiet;
   assign usb_quiet = !I_USB_DONE && !I_USB_UBF_SET && !I_USB_DIR_SET;
   sequence s_clear_ep0_alone;
      clr && I_EP_SEL == 4'h0 && !I_WDATA[`UEBA_B_ESP];
   endsequence
   sequence s_good_read;
      data_rd_go ##1 O_RD_VALID;
   endsequence
   AST_CLR_OFFSET: assert property (
      clr |=> off_ff[$past(I_EP_SEL)] == 6'h00)
      else $error("offset not zero after clear");
   AST_CLR_FLAGS: assert property (
      clr && usb_quiet |=> !cbf_ff[$past(I_EP_SEL)]
                           && !ubf_ff[$past(I_EP_SEL)])
      else $error("full flags not cleared");
   AST_CLR_KEEPS_DIR: assert property (
      clr && !I_USB_DIR_SET |=> dir_ff == $past(dir_ff))
      else $error("clear changed direction");
   AST_CMD_READ_ZERO: assert property (
      I_RD && sel == UEBA_R_STAT |=> O_RDATA[4:0] == 5'h00)
      else $error("command bits read nonzero");
   AST_ESP_KEPT: assert property (
      clr && I_EP_SEL == 4'h0 && I_WDATA[`UEBA_B_ESP] |=> O_STATUS_PHASE_EN)
      else $error("status enable lost with clear");
   AST_ESP_CLEARED: assert property (
      s_clear_ep0_alone |=> !O_STATUS_PHASE_EN)
      else $error("status enable kept by lone clear");
   AST_PREDICT_IGNORED: assert property (
      clr && (I_WDATA[`UEBA_B_SETRD] || I_WDATA[`UEBA_B_SETWR])
      && !I_USB_DIR_SET |=> $stable(dir_ff))
      else $error("prediction taken with clear");
   AST_DONE_MARK: assert property (
      done && !clr && usb_quiet |=> cbf_ff[$past(I_EP_SEL)] == $past(ep_dir))
      else $error("done marked wrong state");
   AST_DONE_LEN: assert property (
      done && ep_dir && ep_inc
      |=> len_ff[$past(I_EP_SEL)] == {1'h0, $past(off_ff[I_EP_SEL])})
      else $error("length not copied on done");
   AST_PAGE_SINGLE: assert property (
      !I_DUAL_BUF[I_EP_SEL] |-> cpu_addr[8] == base_ff[I_EP_SEL][`UEBA_B_PAGE])
      else $error("page select not applied");
   AST_SETUP_STORE: assert property (
      I_USB_SETUP_WE |=> mem[{1'b0, 5'h00, $past(I_USB_SETUP_IDX)}]
                          == $past(I_USB_WDATA))
      else $error("setup byte misplaced");
   AST_BASE_LOW_ZERO: assert property (
      I_RD && sel == UEBA_R_BASE |=> O_RDATA[1:0] == 2'h0)
      else $error("base low bits nonzero");
   AST_LEN_LOCK: assert property (
      I_WR && sel == UEBA_R_LEN && I_INIT_LOCK
      |=> len_ff[$past(I_EP_SEL)] == $past(len_ff[I_EP_SEL]))
      else $error("length written under lock");
   AST_OFF_REFUSED: assert property (
      I_WR && sel == UEBA_R_OFF && !legal
      |=> off_ff[$past(I_EP_SEL)] == $past(off_ff[I_EP_SEL]))
      else $error("illegal offset write taken");
   AST_READ_DATA: assert property (
      s_good_read |-> O_RDATA == $past(mem[cpu_addr]))
      else $error("wrong byte read");
   AST_NO_DATA: assert property (
      data_bad ##1 !fifo_valid |-> O_NO_DATA[$past(I_EP_SEL)])
      else $error("no-data flag not set");
   AST_AUTO_INC: assert property (
      (data_wr_go || data_rd_go) && ep_inc
      |=> off_ff[$past(I_EP_SEL)] == $past(off_ff[I_EP_SEL]) + 6'h01)
      else $error("offset not advanced");
endmodule : ueba_top
`default_nettype wire

// >>> verilog/ueba_params.svh
// constants for the endpoint buffer access block
`ifndef UEBA_PARAMS_SVH
`define UEBA_PARAMS_SVH
// status register bit positions
`define UEBA_B_UBF 7
`define UEBA_B_CBF 6
`define UEBA_B_DIR 5
`define UEBA_B_ESP 4
`define UEBA_B_SETRD 3
`define UEBA_B_SETWR 2
`define UEBA_B_CLR 1
`define UEBA_B_DONE 0
// base register fields
`define UEBA_B_PAGE 7
`define UEBA_B_ADR_HI 6
`define UEBA_B_ADR_LO 2
// reset values
`define UEBA_STAT_RST 8'h20
`define UEBA_DIR_RST 1'b1
`define UEBA_BASE_RST 8'h00
`define UEBA_LEN_RST 7'h00
`define UEBA_OFF_RST 6'h00
`define UEBA_DATA_RST 8'h00
// memory shape: two pages of 256 bytes
`define UEBA_MEM_WORDS 512
`define UEBA_SETUP_PAGE 1'b0
`define UEBA_SETUP_BASE 5'h00
`endif

// >>> verilog/ueba_pkg.sv
// types of the endpoint buffer access block
`default_nettype none
package ueba_pkg;
   typedef enum logic [2:0] {
      UEBA_R_STAT = 3'h0,
      UEBA_R_BASE = 3'h1,
      UEBA_R_LEN  = 3'h2,
      UEBA_R_OFF  = 3'h3,
      UEBA_R_DATA = 3'h4
   } ueba_reg_t;
endpackage : ueba_pkg
`default_nettype wire

// >>> testbench/ueba_usb_model.sv
// usb side model: memory bytes, packet done, buffer full, setup bytes
`default_nettype none
module ueba_usb_model (
   input wire logic i_clk,
   input wire logic [7:0] i_usb_rdata,
   output logic [3:0] o_ep,
   output logic o_we,
   output logic o_re,
   output logic [8:0] o_addr,
   output logic [7:0] o_wdata,
   output logic o_done,
   output logic o_ubf_set,
   output logic o_setup_we,
   output logic [2:0] o_setup_idx
);
   timeunit 1ns;
   timeprecision 1ps;

   initial begin
      {o_ep, o_we, o_re, o_addr, o_wdata} = 23'h0;
      {o_done, o_ubf_set, o_setup_we, o_setup_idx} = 6'h00;
   end

   ////////////////////////////////////////////////////////////////////////
   // released data lines show the inverse, never a stale byte
   task automatic usb_wr(input logic [8:0] a, input logic [7:0] d);
      @(posedge i_clk);
      o_we <= 1'h1;
      o_addr <= a;
      o_wdata <= d;
      @(posedge i_clk);
      o_we <= 1'h0;
      o_wdata <= ~d;
   endtask : usb_wr

   task automatic usb_rd(input logic [8:0] a, output logic [7:0] d);
      @(posedge i_clk);
      o_re <= 1'h1;
      o_addr <= a;
      @(posedge i_clk);
      o_re <= 1'h0;
      #1;
      d = i_usb_rdata;
   endtask : usb_rd

   // full=1 marks the usb buffer full, full=0 ends a packet
   task automatic usb_done(input logic [3:0] ep, input logic full);
      @(posedge i_clk);
      o_ep <= ep;
      o_done <= ~full;
      o_ubf_set <= full;
      @(posedge i_clk);
      o_done <= 1'h0;
      o_ubf_set <= 1'h0;
   endtask : usb_done

   task automatic setup_wr(input logic [2:0] idx, input logic [7:0] d);
      @(posedge i_clk);
      o_setup_we <= 1'h1;
      o_setup_idx <= idx;
      o_wdata <= d;
      @(posedge i_clk);
      o_setup_we <= 1'h0;
      o_wdata <= ~d;
   endtask : setup_wr
endmodule : ueba_usb_model
`default_nettype wire

// >>> testbench/usb_endpoint_buffer_access_bench.sv
// self-checking bench of the endpoint buffer access block
`default_nettype none
module usb_endpoint_buffer_access_bench import ueba_pkg::*;;
   timeunit 1ns;
   timeprecision 1ps;

   logic clk, arst_n, wr, rd, lock, v, u_we, u_re, u_done, ubf_set;
   logic s_we, esp;
   logic [3:0] ep_sel, u_ep;
   logic [2:0] reg_sel, s_idx;
   logic [7:0] wdata, rdata, u_wdata, u_rdata, d;
   logic rd_valid, wr_ready;
   logic [8:0] u_addr;
   logic [15:0] auto_inc, nd_clr, no_data, dual;
   int miscompares = 0;
   int n_tests = 0;

   ueba_top i_ueba_top (
      .I_CLK(clk), .I_ARST_N(arst_n), .I_EP_SEL(ep_sel),
      .I_REG_SEL(reg_sel), .I_WR(wr), .I_RD(rd), .I_WDATA(wdata),
      .O_RDATA(rdata), .O_RD_VALID(rd_valid), .O_WR_READY(wr_ready),
      .I_INIT_LOCK(lock), .I_AUTO_INC(auto_inc),
      .I_DUAL_BUF(dual), .I_USB_EP(u_ep), .I_USB_WE(u_we),
      .I_USB_RE(u_re), .I_USB_ADDR(u_addr), .I_USB_WDATA(u_wdata),
      .I_USB_DONE(u_done), .I_USB_UBF_SET(ubf_set),
      .I_USB_UBF_CLR(1'h0), .I_USB_DIR_SET(1'h0), .I_USB_DIR(1'h0),
      .I_USB_SETUP_WE(s_we), .I_USB_SETUP_IDX(s_idx),
      .I_STATUS_DONE(1'h0), .I_NO_DATA_CLR(nd_clr),
      .O_USB_RDATA(u_rdata), .O_NO_DATA(no_data),
      .O_STATUS_PHASE_EN(esp)
   );

   ueba_usb_model i_ueba_usb_model (
      .i_clk(clk), .i_usb_rdata(u_rdata), .o_ep(u_ep), .o_we(u_we),
      .o_re(u_re), .o_addr(u_addr), .o_wdata(u_wdata), .o_done(u_done),
      .o_ubf_set(ubf_set), .o_setup_we(s_we), .o_setup_idx(s_idx)
   );

   initial begin
      clk = 1'h0;
      forever #5 clk = ~clk;
   end

   ////////////////////////////////////////////////////////////////////////
   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      n_tests++;
      if (seen !== exp) begin
         miscompares++;
         $display("BAD %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask : check

   task automatic cpu_wr(input logic [3:0] ep, input logic [2:0] r,
                         input logic [7:0] wd);
      @(posedge clk);
      wr <= 1'h1;
      ep_sel <= ep;
      reg_sel <= r;
      wdata <= wd;
      @(posedge clk);
      wr <= 1'h0;
      wdata <= ~wd;
   endtask : cpu_wr

   task automatic cpu_rd(input logic [3:0] ep, input logic [2:0] r);
      @(posedge clk);
      rd <= 1'h1;
      ep_sel <= ep;
      reg_sel <= r;
      @(posedge clk);
      rd <= 1'h0;
      #1;
      v = rd_valid;
      d = rdata;
   endtask : cpu_rd

   task automatic rd_chk(input logic [3:0] ep, input logic [2:0] r,
                         input logic [7:0] exp);
      cpu_rd(ep, r);
      check({7'h00, v}, 8'h01);
      check(d, exp);
   endtask : rd_chk

   task automatic final_report();
      $display("comparisons %0d mismatches %0d", n_tests, miscompares);
      if (miscompares == 0 && n_tests > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask : final_report

   initial begin
      repeat (6000) @(posedge clk);
      miscompares++;
      final_report();
   end

   ////////////////////////////////////////////////////////////////////////
   initial begin
      arst_n = 1'h0;
      {wr, rd, lock, ep_sel, reg_sel, wdata} = 18'h0;
      nd_clr = 16'h0000;
      auto_inc = 16'h0006;
      dual = 16'h0010;
      repeat (16) @(posedge clk);
      arst_n <= 1'h1;
      rd_chk(4'h0, UEBA_R_STAT, 8'h20);
      check({7'h00, wr_ready}, 8'h01);
      rd_chk(4'h0, UEBA_R_OFF, 8'h00);
      cpu_wr(4'h0, UEBA_R_BASE, 8'hFF);
      rd_chk(4'h0, UEBA_R_BASE, 8'hFC);
      rd_chk(4'h1, UEBA_R_BASE, 8'h00);
      // cpu to usb: three bytes at start 10h, page 0
      cpu_wr(4'h1, UEBA_R_BASE, 8'h08);
      for (int i = 0; i < 3; i++) begin
         cpu_wr(4'h1, UEBA_R_DATA, 8'hA0 + 8'(i));
      end
      repeat (4) @(posedge clk);
      rd_chk(4'h1, UEBA_R_OFF, 8'h03);
      for (int i = 0; i < 3; i++) begin
         i_ueba_usb_model.usb_rd({1'h0, 8'h10 + 8'(i)}, d);
         check(d, 8'hA0 + 8'(i));
      end
      cpu_wr(4'h1, UEBA_R_STAT, 8'h01);
      rd_chk(4'h1, UEBA_R_STAT, 8'h60);
      rd_chk(4'h1, UEBA_R_LEN, 8'h03);
      // cpu buffer full: data and offset writes refused
      cpu_wr(4'h1, UEBA_R_DATA, 8'h55);
      @(posedge clk);
      #1;
      check({7'h00, no_data[1]}, 8'h01);
      cpu_wr(4'h1, UEBA_R_OFF, 8'h11);
      rd_chk(4'h1, UEBA_R_OFF, 8'h03);
      cpu_rd(4'h1, UEBA_R_DATA);
      check({7'h00, v}, 8'h00);
      @(posedge clk);
      nd_clr <= 16'h0002;
      @(posedge clk);
      nd_clr <= 16'h0000;
      #1;
      check({7'h00, no_data[1]}, 8'h00);
      // clear with a prediction keeps the direction
      i_ueba_usb_model.usb_done(4'h1, 1'h1);
      rd_chk(4'h1, UEBA_R_STAT, 8'hE0);
      cpu_wr(4'h1, UEBA_R_STAT, 8'h06);
      rd_chk(4'h1, UEBA_R_STAT, 8'h20);
      rd_chk(4'h1, UEBA_R_OFF, 8'h00);
      cpu_wr(4'h1, UEBA_R_STAT, 8'h04);
      rd_chk(4'h1, UEBA_R_STAT, 8'h00);
      // usb to cpu on page 1, start 20h
      cpu_wr(4'h2, UEBA_R_BASE, 8'h90);
      cpu_wr(4'h2, UEBA_R_STAT, 8'h04);
      for (int i = 0; i < 3; i++) begin
         i_ueba_usb_model.usb_wr({1'h1, 8'h20 + 8'(i)}, 8'hC0 + 8'(i));
      end
      i_ueba_usb_model.usb_done(4'h2, 1'h0);
      rd_chk(4'h2, UEBA_R_STAT, 8'h40);
      for (int i = 0; i < 3; i++) begin
         rd_chk(4'h2, UEBA_R_DATA, 8'hC0 + 8'(i));
      end
      cpu_wr(4'h2, UEBA_R_STAT, 8'h01);
      rd_chk(4'h2, UEBA_R_STAT, 8'h00);
      rd_chk(4'h2, UEBA_R_LEN, 8'h00);
      // length lock, field widths, done without auto-increment
      @(posedge clk);
      lock <= 1'h1;
      cpu_wr(4'h3, UEBA_R_LEN, 8'h15);
      rd_chk(4'h3, UEBA_R_LEN, 8'h00);
      @(posedge clk);
      lock <= 1'h0;
      cpu_wr(4'h3, UEBA_R_LEN, 8'hFF);
      rd_chk(4'h3, UEBA_R_LEN, 8'h7F);
      cpu_wr(4'h3, UEBA_R_OFF, 8'hFF);
      rd_chk(4'h3, UEBA_R_OFF, 8'h3F);
      cpu_wr(4'h3, UEBA_R_STAT, 8'h01);
      rd_chk(4'h3, UEBA_R_LEN, 8'h7F);
      // dual buffer mode: page bit set, byte still lands on page 0
      cpu_wr(4'h4, UEBA_R_BASE, 8'hA0);
      cpu_wr(4'h4, UEBA_R_DATA, 8'h5A);
      repeat (2) @(posedge clk);
      i_ueba_usb_model.usb_rd(9'h040, d);
      check(d, 8'h5A);
      // status phase enable of endpoint zero
      cpu_wr(4'h0, UEBA_R_STAT, 8'h12);
      #1;
      check({7'h00, esp}, 8'h01);
      cpu_wr(4'h0, UEBA_R_STAT, 8'h02);
      #1;
      check({7'h00, esp}, 8'h00);
      i_ueba_usb_model.setup_wr(3'h5, 8'h3C);
      i_ueba_usb_model.usb_rd(9'h005, d);
      check(d, 8'h3C);
      final_report();
   end
endmodule : usb_endpoint_buffer_access_bench
`default_nettype wire
